// file: rtl/stcc_pkg.sv
// constants, commands and states of the sensor teach and setting controller
// Function
// - after mark acquisition, next button press acquires the background
// - successful acquisition holds ready indicator steadily on
// - insufficient contrast blinks ready indicator fast
// - button press during failure blink restores previous setting
// - master commands tp1 and tp2 equal mark and background steps
// - mark variant: 5 s hold or command sets max sensitivity, indicator off
// - 10 s hold forces switching output pin back to pnp
// - reflector variants: 3 s hold or command sets max sensitivity
// - reflector variants: short hold or single value command acquires reflector
// - tracking variant readjusts threshold after 1 minute of low signal
// - tracking variant: signal too weak to compensate holds switching output on
// - trimmer selects polarity: counterclockwise light, clockwise dark
// - master switching channel config can also select light or dark
// - remote input high means pressed, low or open means released
// - process input data 4 bits, or 5 with alarm; no output data
// - lock, teach channel, emitter and keylock indices excluded from storage
// - output type setting turns the output pin into remote input
package stcc_pkg;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_DS_QUERY = 8'h14;
  // ctrl fields
  localparam int CTRL_SSC_EN = 0;
  localparam int CTRL_SSC_DARK = 1;
  localparam int CTRL_REMOTE_SEL = 2;
  localparam int CTRL_PNP = 3;
  localparam logic [3:0] CTRL_RESET = 4'h8;
  // irq fields
  localparam int IRQ_OK = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_MAXS = 2;
  localparam int IRQ_PNP = 3;
  localparam int IRQ_TRACK = 4;
  localparam int IRQ_W = 5;
  // ************************************************************
  // master commands
  // ************************************************************
  localparam logic [3:0] CMD_TP1 = 4'h1;
  localparam logic [3:0] CMD_TP2 = 4'h2;
  localparam logic [3:0] CMD_SINGLE = 4'h3;
  localparam logic [3:0] CMD_MAXS = 4'h4;
  // indices kept out of data storage
  localparam logic [15:0] IDX_LOCKS = 16'h000C;
  localparam logic [15:0] IDX_TEACH_CH = 16'h003A;
  localparam logic [15:0] IDX_EMITTER = 16'h0051;
  localparam logic [15:0] IDX_KEYLOCK = 16'h0058;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_MS = 20;
  localparam int BLINK_HALF_MS = 100;
  localparam int HOLD_REFL_MAXS_MS = 3000;
  localparam int HOLD_MARK_MAXS_MS = 5000;
  localparam int HOLD_PNP_MS = 10000;
  localparam int TRACK_LOW_MS = 60000;
  // variants
  localparam logic [1:0] VAR_MARK = 2'h0;
  localparam logic [1:0] VAR_REFL = 2'h1;
  localparam logic [1:0] VAR_TRACK = 2'h2;
  // acquisition kinds
  localparam logic [1:0] ACQ_MARK = 2'h0;
  localparam logic [1:0] ACQ_BACK = 2'h1;
  localparam logic [1:0] ACQ_REFL = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_FAIL} stcc_state_t;
endpackage

// file: rtl/stcc_top.sv
// sensor teach and setting controller, avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
module stcc_top #(
  parameter logic [1:0] VARIANT = stcc_pkg::VAR_MARK,
  parameter int PD_BITS = 4,
  parameter int MS_CYCLES = stcc_pkg::CYC_PER_MS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic button_pin,
  input wire logic remote_pin,
  input wire logic mode_trimmer_cw,
  input wire logic acq_done,
  input wire logic acq_ok,
  input wire logic object_present,
  input wire logic signal_low,
  input wire logic signal_too_weak,
  output logic acq_start,
  output logic [1:0] acq_kind,
  output logic restore_setting,
  output logic max_sens_set,
  output logic thr_adjust,
  output logic out_pnp,
  output logic remote_sel,
  output logic switch_out,
  output logic switch_state_indicator,
  output logic teach_status_indicator,
  output logic [4:0] pd_in,
  output logic irq
);
  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic ds_excluded(input logic [15:0] idx);
    ds_excluded = (idx == stcc_pkg::IDX_LOCKS) || (idx == stcc_pkg::IDX_TEACH_CH) ||
                  (idx == stcc_pkg::IDX_EMITTER) || (idx == stcc_pkg::IDX_KEYLOCK);
  endfunction

  function automatic logic sync_agree(input logic [2:0] s);
    sync_agree = s[1] == s[2];
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] btn_sync_reg;
  logic [2:0] rem_sync_reg;
  logic [2:0] trim_sync_reg;
  logic btn_lvl_reg;
  logic rem_lvl_reg;
  logic trim_lvl_reg;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      btn_sync_reg <= 3'h0;
      rem_sync_reg <= 3'h0;
      trim_sync_reg <= 3'h0;
    end else if (clk_en) begin
      btn_sync_reg <= {btn_sync_reg[1:0], button_pin};
      rem_sync_reg <= {rem_sync_reg[1:0], remote_pin};
      trim_sync_reg <= {trim_sync_reg[1:0], mode_trimmer_cw};
    end
  end
  // only stages two and three are compared, stage one feeds stage two alone
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      btn_lvl_reg <= 1'b0;
      rem_lvl_reg <= 1'b0;
      trim_lvl_reg <= 1'b0;
    end else if (clk_en) begin
      if (sync_agree(btn_sync_reg)) btn_lvl_reg <= btn_sync_reg[2];
      if (sync_agree(rem_sync_reg)) rem_lvl_reg <= rem_sync_reg[2];
      if (sync_agree(trim_sync_reg)) trim_lvl_reg <= trim_sync_reg[2];
    end
  end

  // ************************************************************
  // millisecond tick
  // ************************************************************
  logic [31:0] ms_div_reg;
  logic ms_tick;
  assign ms_tick = ms_div_reg == 32'(MS_CYCLES - 1);
  always_ff @(posedge sys_clk) begin
    if (reset) ms_div_reg <= 32'h0000_0000;
    else if (clk_en) ms_div_reg <= ms_tick ? 32'h0000_0000 : ms_div_reg + 32'h0000_0001;
  end

  // ************************************************************
  // control register and press debounce
  // ************************************************************
  logic [3:0] ctrl_reg;
  logic raw_press;
  logic press_reg;
  logic [4:0] deb_cnt_reg;
  assign raw_press = btn_lvl_reg | (ctrl_reg[stcc_pkg::CTRL_REMOTE_SEL] & rem_lvl_reg);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      press_reg <= 1'b0;
      deb_cnt_reg <= 5'h00;
    end else if (clk_en) begin
      if (raw_press == press_reg) deb_cnt_reg <= 5'h00;
      else if (ms_tick) begin
        if (deb_cnt_reg == 5'(stcc_pkg::DEBOUNCE_MS - 1)) begin
          press_reg <= raw_press;
          deb_cnt_reg <= 5'h00;
        end else deb_cnt_reg <= deb_cnt_reg + 5'h01;
      end
    end
  end

  // ************************************************************
  // hold timer
  // ************************************************************
  logic press_d_reg;
  logic [13:0] hold_ms_reg;
  logic release_evt;
  logic hold_short;
  logic hold_maxs;
  logic hold_pnp;
  localparam int MAXS_MS = (VARIANT == stcc_pkg::VAR_MARK) ?
                           stcc_pkg::HOLD_MARK_MAXS_MS : stcc_pkg::HOLD_REFL_MAXS_MS;
  assign release_evt = press_d_reg & ~press_reg;
  assign hold_pnp = hold_ms_reg >= 14'(stcc_pkg::HOLD_PNP_MS);
  assign hold_maxs = !hold_pnp && hold_ms_reg >= 14'(MAXS_MS);
  assign hold_short = !hold_pnp && !hold_maxs;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      press_d_reg <= 1'b0;
      hold_ms_reg <= 14'h0000;
    end else if (clk_en) begin
      press_d_reg <= press_reg;
      if (!press_reg) hold_ms_reg <= 14'h0000;
      else if (ms_tick && !hold_pnp) hold_ms_reg <= hold_ms_reg + 14'h0001;
    end
  end

  // ************************************************************
  // avalon slave
  // ************************************************************
  logic access;
  logic wr_en;
  logic cmd_wr;
  logic [3:0] cmd_code;
  localparam int IRQ_BITS = stcc_pkg::IRQ_W;
  logic [IRQ_BITS-1:0] irq_stat_reg;
  logic [IRQ_BITS-1:0] irq_mask_reg;
  logic [IRQ_BITS-1:0] irq_set;
  logic [15:0] ds_idx_reg;
  logic [31:0] rd_mux;
  assign access = (avs_read | avs_write) & avs_waitrequest;
  assign wr_en = clk_en & avs_write & ~avs_waitrequest;
  assign cmd_wr = wr_en && avs_address == stcc_pkg::REG_CMD;
  assign cmd_code = avs_writedata[3:0];
  // one wait state, then data and write take effect together
  always_ff @(posedge sys_clk) begin
    if (reset) avs_waitrequest <= 1'b1;
    else if (clk_en) avs_waitrequest <= ~access;
  end
  always_ff @(posedge sys_clk) begin
    if (reset) avs_readdata <= 32'h0000_0000;
    else if (clk_en && access) avs_readdata <= rd_mux;
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ds_idx_reg <= 16'h0000;
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      if (avs_address == stcc_pkg::REG_DS_QUERY) ds_idx_reg <= avs_writedata[15:0];
      if (avs_address == stcc_pkg::REG_IRQ_MASK) irq_mask_reg <= avs_writedata[IRQ_BITS-1:0];
    end
  end
  // set beats a same-cycle write-one clear
  always_ff @(posedge sys_clk) begin
    if (reset) irq_stat_reg <= '0;
    else if (clk_en) begin
      if (wr_en && avs_address == stcc_pkg::REG_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~avs_writedata[IRQ_BITS-1:0]) | irq_set;
      else irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) irq <= 1'b0;
    else if (clk_en) irq <= |(irq_stat_reg & irq_mask_reg);
  end

  // ************************************************************
  // teach sequencer
  // ************************************************************
  stcc_pkg::stcc_state_t state_reg;
  logic mark_done_reg;
  logic ready_on_reg;
  logic maxs_reg;
  logic pnp_evt;
  logic maxs_evt;
  logic teach_req;
  logic [1:0] teach_kind;
  logic [6:0] blink_cnt_reg;
  logic blink_reg;
  always_comb begin
    teach_req = 1'b0;
    teach_kind = stcc_pkg::ACQ_MARK;
    maxs_evt = cmd_wr && cmd_code == stcc_pkg::CMD_MAXS;
    pnp_evt = release_evt && hold_pnp;
    if (release_evt && hold_maxs) maxs_evt = 1'b1;
    if (VARIANT == stcc_pkg::VAR_MARK) begin
      if (cmd_wr && cmd_code == stcc_pkg::CMD_TP1) teach_req = 1'b1;
      if (cmd_wr && cmd_code == stcc_pkg::CMD_TP2) begin
        teach_req = 1'b1;
        teach_kind = stcc_pkg::ACQ_BACK;
      end
      if (release_evt && hold_short) begin
        teach_req = 1'b1;
        teach_kind = mark_done_reg ? stcc_pkg::ACQ_BACK : stcc_pkg::ACQ_MARK;
      end
    end else begin
      if ((release_evt && hold_short) || (cmd_wr && cmd_code == stcc_pkg::CMD_SINGLE)) begin
        teach_req = 1'b1;
        teach_kind = stcc_pkg::ACQ_REFL;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= stcc_pkg::ST_IDLE;
      mark_done_reg <= 1'b0;
      ready_on_reg <= 1'b1;
      maxs_reg <= 1'b0;
      acq_start <= 1'b0;
      acq_kind <= stcc_pkg::ACQ_MARK;
      restore_setting <= 1'b0;
      max_sens_set <= 1'b0;
      irq_set <= '0;
    end else if (clk_en) begin
      acq_start <= 1'b0;
      restore_setting <= 1'b0;
      max_sens_set <= 1'b0;
      irq_set <= '0;
      irq_set[stcc_pkg::IRQ_PNP] <= pnp_evt;
      unique case (state_reg)
        stcc_pkg::ST_IDLE: begin
          if (teach_req) begin
            acq_start <= 1'b1;
            acq_kind <= teach_kind;
            state_reg <= stcc_pkg::ST_ACQ;
          end else if (maxs_evt) begin
            // mark variant goes dark, reflector lights
            max_sens_set <= 1'b1;
            maxs_reg <= 1'b1;
            mark_done_reg <= 1'b0;
            ready_on_reg <= VARIANT != stcc_pkg::VAR_MARK;
            irq_set[stcc_pkg::IRQ_MAXS] <= 1'b1;
          end
        end
        stcc_pkg::ST_ACQ: begin
          if (acq_done) begin
            if (acq_ok) begin
              ready_on_reg <= 1'b1;
              maxs_reg <= 1'b0;
              mark_done_reg <= acq_kind == stcc_pkg::ACQ_MARK;
              irq_set[stcc_pkg::IRQ_OK] <= 1'b1;
              state_reg <= stcc_pkg::ST_IDLE;
            end else begin
              irq_set[stcc_pkg::IRQ_FAIL] <= 1'b1;
              state_reg <= stcc_pkg::ST_FAIL;
            end
          end
        end
        stcc_pkg::ST_FAIL: begin
          if (release_evt) begin
            restore_setting <= 1'b1;
            mark_done_reg <= 1'b0;
            ready_on_reg <= 1'b1;
            state_reg <= stcc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      blink_cnt_reg <= 7'h00;
      blink_reg <= 1'b0;
    end else if (clk_en && ms_tick) begin
      if (blink_cnt_reg == 7'(stcc_pkg::BLINK_HALF_MS - 1)) begin
        blink_cnt_reg <= 7'h00;
        blink_reg <= ~blink_reg;
      end else blink_cnt_reg <= blink_cnt_reg + 7'h01;
    end
  end
  // hold feedback: lit only while the max sensitivity hold window is open
  always_ff @(posedge sys_clk) begin
    if (reset) teach_status_indicator <= 1'b1;
    else if (clk_en) begin
      if (state_reg == stcc_pkg::ST_FAIL) teach_status_indicator <= blink_reg;
      else if (state_reg == stcc_pkg::ST_ACQ) teach_status_indicator <= 1'b0;
      else if (press_reg) teach_status_indicator <= hold_maxs;
      else teach_status_indicator <= ready_on_reg;
    end
  end

  // ************************************************************
  // control and pin mode
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) ctrl_reg <= stcc_pkg::CTRL_RESET;
    else if (clk_en) begin
      if (wr_en && avs_address == stcc_pkg::REG_CTRL) ctrl_reg <= avs_writedata[3:0];
      if (pnp_evt) ctrl_reg[stcc_pkg::CTRL_PNP] <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_pnp <= 1'b1;
      remote_sel <= 1'b0;
    end else if (clk_en) begin
      out_pnp <= ctrl_reg[stcc_pkg::CTRL_PNP];
      remote_sel <= ctrl_reg[stcc_pkg::CTRL_REMOTE_SEL];
    end
  end

  // ************************************************************
  // threshold tracking and switching output
  // ************************************************************
  logic [15:0] low_ms_reg;
  logic dark_sel;
  logic out_next;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      low_ms_reg <= 16'h0000;
      thr_adjust <= 1'b0;
    end else if (clk_en) begin
      thr_adjust <= 1'b0;
      if (VARIANT != stcc_pkg::VAR_TRACK || !signal_low || signal_too_weak)
        low_ms_reg <= 16'h0000;
      else if (ms_tick) begin
        if (low_ms_reg == 16'(stcc_pkg::TRACK_LOW_MS - 1)) begin
          low_ms_reg <= 16'h0000;
          thr_adjust <= 1'b1;
        end else low_ms_reg <= low_ms_reg + 16'h0001;
      end
    end
  end
  // master config overrides trimmer, trimmer clockwise is dark
  assign dark_sel = ctrl_reg[stcc_pkg::CTRL_SSC_EN] ? ctrl_reg[stcc_pkg::CTRL_SSC_DARK]
                                                     : trim_lvl_reg;
  assign out_next = (VARIANT == stcc_pkg::VAR_TRACK && signal_too_weak) |
                    (dark_sel ? object_present : ~object_present);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      switch_out <= 1'b0;
      switch_state_indicator <= 1'b0;
      pd_in <= 5'h00;
    end else if (clk_en) begin
      switch_out <= out_next;
      switch_state_indicator <= out_next;
      pd_in[0] <= out_next;
      pd_in[1] <= out_next;
      pd_in[2] <= state_reg != stcc_pkg::ST_IDLE;
      pd_in[3] <= signal_low;
      pd_in[4] <= (PD_BITS > 4) && signal_too_weak;
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      stcc_pkg::REG_CTRL: rd_mux[3:0] = ctrl_reg;
      stcc_pkg::REG_STATUS:
        rd_mux[7:0] = {2'h0, dark_sel, maxs_reg, mark_done_reg, ready_on_reg, state_reg};
      stcc_pkg::REG_IRQ_STAT: rd_mux[IRQ_BITS-1:0] = irq_stat_reg;
      stcc_pkg::REG_IRQ_MASK: rd_mux[IRQ_BITS-1:0] = irq_mask_reg;
      stcc_pkg::REG_DS_QUERY: rd_mux = {15'h0000, ds_excluded(ds_idx_reg), ds_idx_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
endmodule // stcc_top
`default_nettype wire

// file: testbench/stcc_sva.sv
// assertion checker for the sensor teach and setting controller
`timescale 1ns/1ps
`default_nettype none
module stcc_sva #(
  parameter logic [1:0] VARIANT = 2'h0,
  parameter int PD_BITS = 4,
  parameter int MS_CYCLES = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic acq_start,
  input wire logic [1:0] acq_kind,
  input wire logic acq_done,
  input wire logic acq_ok,
  input wire logic restore_setting,
  input wire logic max_sens_set,
  input wire logic teach_status_indicator,
  input wire logic [4:0] pd_in
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ************************************************************
  // bus handshake
  // ************************************************************
  a_bus_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
    |=> !avs_waitrequest) else $error("bus request not answered next cycle");
  a_wait_low_once: assert property (!avs_waitrequest && clk_en |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_no_idle_answer: assert property (!(avs_read || avs_write) && avs_waitrequest
    |=> avs_waitrequest) else $error("answer without request");
  // ************************************************************
  // teach sequence
  // ************************************************************
  a_start_one_pulse: assert property (acq_start |=> !acq_start) else $error("start too long");
  a_start_mark_kind: assert property (
    acq_start |-> (acq_kind == 2'h2) == (VARIANT != 2'h0))
    else $error("acquisition kind wrong for variant");
  a_ok_steady_on: assert property (
    acq_done && acq_ok |-> ##[1:4] teach_status_indicator [*8]) else $error("ready not steady");
  // ranges fit the short sim timebase only (one cycle per ms)
  a_fail_fast_blink: assert property (
    MS_CYCLES == 1 && acq_done && !acq_ok |-> ##[1:250] $rose(teach_status_indicator)
    ##[95:105] $fell(teach_status_indicator)) else $error("no fast blink after failure");
  a_restore_only: assert property (
    restore_setting |-> !acq_start && !max_sens_set) else $error("restore mixed with action");
  a_maxs_dark: assert property (
    VARIANT == 2'h0 && max_sens_set |-> ##[0:4] !teach_status_indicator [*4])
    else $error("ready lit at max sens");
  a_pd_width: assert property (
    PD_BITS > 4 || pd_in[4] == 1'b0) else $error("alarm bit set in 4 bit variant");
endmodule // stcc_sva
bind stcc_top stcc_sva #(.VARIANT(VARIANT), .PD_BITS(PD_BITS), .MS_CYCLES(MS_CYCLES)) u_sva (
  .sys_clk, .reset,
  .clk_en, .avs_read, .avs_write, .avs_waitrequest, .acq_start, .acq_kind, .acq_done,
  .acq_ok, .restore_setting, .max_sens_set, .teach_status_indicator, .pd_in);
`default_nettype wire

// file: testbench/stcc_optic_model.sv
// optical acquisition stand-in for the teach controller
`timescale 1ns/1ps
`default_nettype none
module stcc_optic_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic acq_start,
  input wire logic ok_cfg,
  input wire logic [7:0] delay_cfg,
  output logic acq_done,
  output logic acq_ok
);
  logic [7:0] cnt_reg;
  logic busy_reg;
  logic junk_reg;
  always_ff @(posedge sys_clk) begin
    junk_reg <= ~junk_reg;
    if (reset) begin
      busy_reg <= 1'b0;
      acq_done <= 1'b0;
      junk_reg <= 1'b0;
    end else begin
      acq_done <= busy_reg && cnt_reg == 8'h00;
      if (acq_start) begin
        busy_reg <= 1'b1;
        cnt_reg <= delay_cfg;
      end else if (busy_reg) begin
        busy_reg <= cnt_reg != 8'h00;
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
  // contrast verdict
  // outside the done pulse the verdict toggles, so nothing may lean on it
  assign acq_ok = acq_done ? ok_cfg : junk_reg;
endmodule // stcc_optic_model
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking testbench for the sensor teach and setting controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [7:0] avs_address = 8'h00, dly = 8'h01;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic button_pin = 1'b0, remote_pin = 1'b0, trim_cw = 1'b1, obj = 1'b0, sig_low = 1'b0;
  logic ok_cfg = 1'b1, acq_done, acq_ok, acq_start, restore_setting, max_sens_set, tsi, tsi_prev;
  logic out_pnp, remote_sel, switch_out, ssi, irq, clk_en = 1'b1;
  logic [1:0] acq_kind, last_kind = 2'h3;
  logic [4:0] pd_in;
  logic [15:0] idx[5] = '{16'h000C, 16'h003A, 16'h0051, 16'h0058, 16'h0010};
  int errors = 0, n_compared = 0, cyc = 0, n_start = 0, n_rest = 0, n_maxs = 0, tog;
  always #5 sys_clk = ~sys_clk;
  stcc_top #(.VARIANT(stcc_pkg::VAR_MARK), .PD_BITS(4), .MS_CYCLES(1)) dut (.sys_clk, .reset,
    .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .button_pin, .remote_pin, .mode_trimmer_cw(trim_cw), .acq_done,
    .acq_ok, .object_present(obj), .signal_low(sig_low), .signal_too_weak(1'b0), .acq_start,
    .acq_kind, .restore_setting, .max_sens_set, .thr_adjust(), .out_pnp, .remote_sel,
    .switch_out, .switch_state_indicator(ssi), .teach_status_indicator(tsi), .pd_in, .irq);
  stcc_optic_model optic (.sys_clk, .reset, .acq_start, .ok_cfg, .delay_cfg(dly), .acq_done,
    .acq_ok);
  // ************************************************************
  // event monitor and timeout
  // ************************************************************
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (acq_start === 1'b1) begin
      n_start <= n_start + 1;
      last_kind <= acq_kind;
    end
    if (restore_setting === 1'b1) n_rest <= n_rest + 1;
    if (max_sens_set === 1'b1) n_maxs <= n_maxs + 1;
    if (cyc == 40000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // avalon-mm access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // hold the button n cycles, then leave room for the release debounce
  task automatic press(input int n);
    @(posedge sys_clk);
    button_pin <= 1'b1;
    repeat (n) @(posedge sys_clk);
    button_pin <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask
  // wait for a new start, then until the state leaves acquiring
  task automatic wait_acq(input int n0);
    while (n_start == n0) @(posedge sys_clk);
    do bus(1'b0, stcc_pkg::REG_STATUS, 32'h0000_0000); while (rd[1:0] == 2'h1);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    // the trimmer level needs its synchroniser before the outputs settle
    repeat (8) @(posedge sys_clk);
    bus(1'b0, stcc_pkg::REG_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    chk({24'h0, out_pnp, tsi, irq, pd_in}, 32'h0000_00C0);
    bus(1'b0, 8'h3C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b1, stcc_pkg::REG_IRQ_MASK, 32'h0000_001F);
    press(100);
    wait_acq(0);
    chk({last_kind, tsi}, {stcc_pkg::ACQ_MARK, 1'b1});
    bus(1'b0, stcc_pkg::REG_IRQ_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    chk(irq, 1'b1);
    bus(1'b1, stcc_pkg::REG_IRQ_STAT, 32'h0000_0001);
    bus(1'b0, stcc_pkg::REG_IRQ_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(irq, 1'b0);
    press(100);
    wait_acq(1);
    chk(last_kind, stcc_pkg::ACQ_BACK);
    bus(1'b1, stcc_pkg::REG_CMD, stcc_pkg::CMD_TP1);
    wait_acq(2);
    chk(last_kind, stcc_pkg::ACQ_MARK);
    bus(1'b1, stcc_pkg::REG_CMD, stcc_pkg::CMD_TP2);
    wait_acq(3);
    chk(last_kind, stcc_pkg::ACQ_BACK);
    ok_cfg <= 1'b0;
    dly <= 8'h3C;
    bus(1'b1, stcc_pkg::REG_IRQ_STAT, 32'h0000_001F);
    bus(1'b1, stcc_pkg::REG_CMD, stcc_pkg::CMD_TP1);
    wait_acq(4);
    chk(rd[1:0], 2'h2);
    tog = 0;
    tsi_prev = tsi;
    repeat (400) begin
      @(posedge sys_clk);
      if (tsi !== tsi_prev) tog++;
      tsi_prev = tsi;
    end
    chk(tog, 4);
    bus(1'b1, stcc_pkg::REG_IRQ_MASK, 32'h0000_0001);
    bus(1'b0, stcc_pkg::REG_IRQ_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    chk(irq, 1'b0);
    bus(1'b1, stcc_pkg::REG_CMD, stcc_pkg::CMD_TP1);
    press(100);
    bus(1'b0, stcc_pkg::REG_STATUS, 32'h0000_0000);
    chk(n_start, 32'd5);
    chk(n_rest, 32'd1);
    chk(rd[1:0], 2'h0);
    ok_cfg <= 1'b1;
    bus(1'b1, stcc_pkg::REG_CMD, stcc_pkg::CMD_MAXS);
    repeat (8) @(posedge sys_clk);
    chk(n_maxs, 32'd1);
    chk(tsi, 1'b0);
    press(5100);
    chk(n_maxs, 2);
    bus(1'b1, stcc_pkg::REG_CTRL, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    chk(out_pnp, 1'b0);
    press(10100);
    bus(1'b0, stcc_pkg::REG_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    chk(out_pnp, 1'b1);
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, stcc_pkg::REG_CTRL, r ? 32'h0000_000C : 32'h0000_0008);
      remote_pin <= 1'b1;
      repeat (100) @(posedge sys_clk);
      remote_pin <= 1'b0;
      repeat (60) @(posedge sys_clk);
      chk(remote_sel, r[0]);
      chk(n_start, 32'd5 + r);
    end
    foreach (idx[i]) begin
      bus(1'b1, stcc_pkg::REG_DS_QUERY, {16'h0000, idx[i]});
      bus(1'b0, stcc_pkg::REG_DS_QUERY, 32'h0000_0000);
      chk(rd & 32'h0001_0000, (i < 4) ? 32'h0001_0000 : 32'h0000_0000);
    end
    obj <= 1'b1;
    sig_low <= 1'b1;
    bus(1'b1, stcc_pkg::REG_CTRL, 32'h0000_0008);
    repeat (50) @(posedge sys_clk);
    chk({switch_out, ssi, pd_in[4:3]}, 4'b1101);
    trim_cw <= 1'b0;
    repeat (50) @(posedge sys_clk);
    chk({switch_out, ssi}, 2'b00);
    bus(1'b1, stcc_pkg::REG_CTRL, 32'h0000_000B);
    repeat (10) @(posedge sys_clk);
    chk({switch_out, ssi}, 2'b11);
    // clock enable low must freeze the output state
    clk_en <= 1'b0;
    obj <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({switch_out, ssi}, 2'b11);
    clk_en <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk({switch_out, ssi}, 2'b00);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
